// ---- common/lsm_consts.svh ----
`ifndef LSM_CONSTS_SVH
`define LSM_CONSTS_SVH
// Table size of one four-input lookup table
`define LSM_LUT_W 16
// Distributed memory depth in words
`define LSM_MEM_DEPTH 16
// Distributed memory word width
`define LSM_MEM_W 4
// Width of the read-only port of the paired memory
`define LSM_PDP_W 2
// Memory contents loaded at configuration
`define LSM_MEM_INIT 64'h0
// Counter reset value
`define LSM_CNT_RST 2'h0
`endif

// ---- common/lsm_pkg.sv ----
package lsm_pkg;
  // Operating mode of the slice
  typedef enum logic [1:0] {
    MODE_LOGIC,
    MODE_RIPPLE,
    MODE_RAM,
    MODE_ROM
  } lsm_mode_t;
  // Ripple function select
  typedef enum logic [2:0] {
    OP_ADD,
    OP_SUB,
    OP_ADDSUB,
    OP_UP,
    OP_DOWN,
    OP_UPDN,
    OP_MULT
  } lsm_op_t;
  // Registered results of the slice
  typedef struct packed {
    logic lut0;
    logic lut1;
    logic lut5;
    logic wide;
    logic [1:0] sum;
    logic cout;
    logic cgen;
    logic cprop;
    logic ge;
    logic ne;
    logic le;
    logic [3:0] rdata;
    logic [1:0] rdata2;
  } lsm_out_t;
endpackage

// ---- hw/lsm_slice.sv ----
`timescale 1ns/1ns
`include "lsm_consts.svh"
// Operation
// R1: Four modes: logic, ripple, RAM, ROM
// R2: LUT4 output per input from configuration
// R3: Two LUT4s join into one LUT5
// R4: Wider functions via neighbour chain mux
// R5: Two-bit add, subtract, dynamic add/subtract
// R6: Two-bit counters, async clear, sync preload
// R7: Compare A,B: ge, ne, le
// R8: Partial product block for multipliers
// R9: Fast carry generate and propagate outputs
// R10: Sixteen by four single-port memory
// R11: Sixteen by two independent read port
// R12: Memory preloaded with initial contents
// R13: Clocked write, combinational read
module lsm_slice #(
  parameter int DEPTH = `LSM_MEM_DEPTH,
  parameter int AW = $clog2(DEPTH),
  parameter logic [DEPTH*`LSM_MEM_W-1:0] MEM_INIT = `LSM_MEM_INIT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire lsm_pkg::lsm_mode_t mode,
  input wire logic [`LSM_LUT_W-1:0] lut_cfg_a,
  input wire logic [`LSM_LUT_W-1:0] lut_cfg_b,
  input wire logic [3:0] lut_in_a,
  input wire logic [3:0] lut_in_b,
  input wire logic lut5_sel,
  input wire logic chain_in,
  input wire logic chain_sel,
  input wire lsm_pkg::lsm_op_t op,
  input wire logic [1:0] op_a,
  input wire logic [1:0] op_b,
  input wire logic carry_in,
  input wire logic addsub_add,
  input wire logic fast_carry_config,
  input wire logic mult_bit,
  input wire logic cnt_dir_up,
  input wire logic cnt_aclr,
  input wire logic cnt_load,
  input wire logic [1:0] cnt_load_val,
  input wire logic mem_we,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [`LSM_MEM_W-1:0] mem_wdata,
  input wire logic pseudo_dual_port_ram_cfg,
  input wire logic [AW-1:0] mem_raddr2,
  output lsm_pkg::lsm_out_t slice_out,
  output logic [1:0] cnt
);

  // Result register and its next value
  lsm_pkg::lsm_out_t out_reg;
  lsm_pkg::lsm_out_t out_next;
  // Counter state
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  // Distributed memory words
  logic [`LSM_MEM_W-1:0] mem_reg [DEPTH];
  logic [`LSM_MEM_W-1:0] mem_next [DEPTH];
  // Arithmetic scratch, one spare bit for carry
  logic [2:0] arith;
  logic [1:0] addend_b;
  logic [1:0] pprod;
  logic [1:0] gen_bit;
  logic [1:0] prop_bit;
  logic do_add;
  logic is_count;
  logic lut5_val;

  // Ports come straight from the result flops
  assign slice_out = out_reg;
  // Counter state leaves from its own flop
  assign cnt = cnt_reg;

  // Memory write port, ROM mode never writes
  always_comb begin
    mem_next = mem_reg;
    // R13: clocked write enable
    // R10: single-port word write
    if (mem_we && mode == lsm_pkg::MODE_RAM) begin
      mem_next[mem_addr] = mem_wdata;
    end
  end

  // Contents restored to the configured image on reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // R12: initial contents load
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= MEM_INIT[i*`LSM_MEM_W +: `LSM_MEM_W];
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  // Counter next state; counts only in ripple mode
  always_comb begin
    cnt_next = cnt_reg;
    is_count = (op == lsm_pkg::OP_UP) || (op == lsm_pkg::OP_DOWN) || (op == lsm_pkg::OP_UPDN);
    if (mode == lsm_pkg::MODE_RIPPLE && is_count) begin
      // R6: preload wins over counting
      if (cnt_load) begin
        cnt_next = cnt_load_val;
      end else if (op == lsm_pkg::OP_UP || (op == lsm_pkg::OP_UPDN && cnt_dir_up)) begin
        cnt_next = cnt_reg + 2'h1;
      end else begin
        cnt_next = cnt_reg - 2'h1;
      end
    end
  end

  // Clear is asynchronous so a cascade clears without a clock
  always_ff @(posedge ref_clk or negedge rstn or posedge cnt_aclr) begin
    if (!rstn) begin
      cnt_reg <= `LSM_CNT_RST;
    end else if (cnt_aclr) begin
      // R6: asynchronous clear
      cnt_reg <= `LSM_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Result datapath for all modes
  always_comb begin
    out_next = '0;
    // R5: dynamic add or subtract
    do_add = (op == lsm_pkg::OP_ADD) || (op == lsm_pkg::OP_MULT) ||
             (op == lsm_pkg::OP_ADDSUB && addsub_add);
    // R8: partial product term
    pprod = op_a & {2{mult_bit}};
    // Subtract as A plus inverted B plus carry, carry high means no borrow
    addend_b = do_add ? op_b : ~op_b;
    if (op == lsm_pkg::OP_MULT) begin
      arith = {1'b0, pprod} + {1'b0, op_b} + {2'h0, carry_in};
    end else begin
      arith = {1'b0, op_a} + {1'b0, addend_b} + {2'h0, carry_in};
    end
    // R9: per bit generate and propagate
    gen_bit = (op == lsm_pkg::OP_MULT ? pprod : op_a) & addend_b;
    prop_bit = (op == lsm_pkg::OP_MULT ? pprod : op_a) ^ addend_b;
    // R3: second table on shared inputs
    lut5_val = lut5_sel ? lut_cfg_b[lut_in_a] : lut_cfg_a[lut_in_a];
    // R1: one mode active at a time
    case (mode)
      lsm_pkg::MODE_LOGIC: begin
        // R2: table lookup
        out_next.lut0 = lut_cfg_a[lut_in_a];
        out_next.lut1 = lut_cfg_b[lut_in_b];
        out_next.lut5 = lut5_val;
        // R4: neighbour chain mux
        out_next.wide = chain_sel ? chain_in : lut5_val;
      end
      lsm_pkg::MODE_RIPPLE: begin
        if (is_count) begin
          // Terminal count flags the wrap for the next slice
          out_next.sum = cnt_next;
          out_next.cout = (op == lsm_pkg::OP_DOWN || (op == lsm_pkg::OP_UPDN && !cnt_dir_up)) ?
                          (cnt_reg == 2'h0) : (cnt_reg == 2'h3);
        end else begin
          out_next.sum = arith[1:0];
          out_next.cout = arith[2];
        end
        // Without fast carry the pair stays low to save routing power
        if (fast_carry_config) begin
          out_next.cgen = gen_bit[1] | (prop_bit[1] & gen_bit[0]);
          out_next.cprop = prop_bit[1] & prop_bit[0];
        end
        // R7: operand comparison
        out_next.ge = op_a >= op_b;
        out_next.ne = op_a != op_b;
        out_next.le = op_a <= op_b;
      end
      lsm_pkg::MODE_RAM, lsm_pkg::MODE_ROM: begin
        // R13: combinational array read
        out_next.rdata = mem_reg[mem_addr];
        // R11: independent read-only port
        if (pseudo_dual_port_ram_cfg) begin
          out_next.rdata2 = mem_reg[mem_raddr2][`LSM_PDP_W-1:0];
        end
      end
      default: begin
        out_next = '0;
      end
    endcase
  end

  // Outputs leave from flops for clean fabric timing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  // Checks on the registered outputs
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // First table, five-input join and wide outputs read zero in every other mode
  a_mode_gate: assert property ((mode != lsm_pkg::MODE_LOGIC) |=> // R1
    !slice_out.lut0 && !slice_out.lut5 && !slice_out.wide)
    else $error("logic outputs active outside logic mode");

  // Both tables follow their configured contents
  a_lut4_eval: assert property ((mode == lsm_pkg::MODE_LOGIC) |=> // R2
    slice_out.lut0 == $past(lut_cfg_a[lut_in_a]) &&
    slice_out.lut1 == $past(lut_cfg_b[lut_in_b]))
    else $error("table output differs from configuration");

  // Fifth input high picks the second table
  a_lut5_join: assert property ((mode == lsm_pkg::MODE_LOGIC && lut5_sel) |=> // R3
    slice_out.lut5 == $past(lut_cfg_b[lut_in_a]))
    else $error("five-input join picked wrong table");

  // Wide output passes the neighbour result when chained
  a_wide_chain: assert property ((mode == lsm_pkg::MODE_LOGIC && chain_sel) |=> // R4
    slice_out.wide == $past(chain_in))
    else $error("chain input not passed to wide output");

  // Subtraction adds the inverted operand
  a_add_sub: assert property ((mode == lsm_pkg::MODE_RIPPLE && op == lsm_pkg::OP_SUB) |=> // R5
    {slice_out.cout, slice_out.sum} == 3'({1'b0, $past(op_a)} + {1'b0, ~$past(op_b)} + {2'h0, $past(carry_in)}))
    else $error("subtraction result wrong");

  // Plain addition and dynamic control set to add
  a_add_result: assert property ((mode == lsm_pkg::MODE_RIPPLE && (op == lsm_pkg::OP_ADD || // R5
    (op == lsm_pkg::OP_ADDSUB && addsub_add))) |=>
    {slice_out.cout, slice_out.sum} == 3'({1'b0, $past(op_a)} + {1'b0, $past(op_b)} + {2'h0, $past(carry_in)}))
    else $error("addition result wrong");

  // Preload taken, then no clear in the following cycle
  sequence s_load_taken;
    mode == lsm_pkg::MODE_RIPPLE && is_count && cnt_load && !cnt_aclr;
  endsequence
  sequence s_no_clear;
    !cnt_aclr;
  endsequence
  a_count_load: assert property (s_load_taken ##1 s_no_clear |-> cnt == $past(cnt_load_val)) // R6
    else $error("counter preload lost");

  // One up step without preload or clear, wrapping at the top
  sequence s_up_step;
    mode == lsm_pkg::MODE_RIPPLE && op == lsm_pkg::OP_UP && !cnt_load && !cnt_aclr;
  endsequence
  a_count_step: assert property (s_up_step ##1 s_no_clear |-> cnt == $past(cnt) + 2'h1) // R6
    else $error("up count did not step");

  // Clear level overrides everything
  a_count_clear: assert property (cnt_aclr |-> cnt == `LSM_CNT_RST) // R6
    else $error("counter not cleared");

  // Every flag exact, so a stuck flag is caught
  a_cmp_flags: assert property ((mode == lsm_pkg::MODE_RIPPLE) |=> // R7
    slice_out.ne == ($past(op_a) != $past(op_b)) && slice_out.ge == ($past(op_a) >= $past(op_b)) &&
    slice_out.le == ($past(op_a) <= $past(op_b)))
    else $error("comparison flags wrong");

  // Multiplier bit low gates the partial product
  a_mult_pp: assert property ((mode == lsm_pkg::MODE_RIPPLE && op == lsm_pkg::OP_MULT && !mult_bit) |=> // R8
    {slice_out.cout, slice_out.sum} == {1'b0, $past(op_b)} + {2'h0, $past(carry_in)})
    else $error("partial product not gated");

  // All-propagate operand pair
  a_carry_gp: assert property ((mode == lsm_pkg::MODE_RIPPLE && fast_carry_config && op == lsm_pkg::OP_ADD // R9
    && op_a == 2'h3 && op_b == 2'h0) |=> slice_out.cprop && !slice_out.cgen)
    else $error("carry propagate wrong");

  // Carry pair held low when the option is off
  a_carry_off: assert property ((mode == lsm_pkg::MODE_RIPPLE && !fast_carry_config) |=> // R9
    !slice_out.cgen && !slice_out.cprop)
    else $error("carry pair active without fast carry");

  // Write then read back the same word
  sequence s_write;
    mode == lsm_pkg::MODE_RAM && mem_we;
  endsequence
  sequence s_readback;
    mode == lsm_pkg::MODE_RAM && !mem_we && mem_addr == $past(mem_addr);
  endsequence

  a_ram_write: assert property (s_write ##1 s_readback |=> // R10
    slice_out.rdata == $past(mem_wdata, 2))
    else $error("written word not read back");

  // Read in the cycle of a write returns the old word
  a_rdata_old: assert property ((mode == lsm_pkg::MODE_RAM && mem_we) |=> // R13
    slice_out.rdata == $past(mem_reg[mem_addr]))
    else $error("read during write not old word");

  // Second port follows its own address in both memory modes
  a_pdp_read: assert property ((mode inside {lsm_pkg::MODE_RAM, lsm_pkg::MODE_ROM} && pseudo_dual_port_ram_cfg) |=> // R11
    slice_out.rdata2 == $past(mem_reg[mem_raddr2][1:0]))
    else $error("second read port wrong");

  // Read-only mode leaves the array untouched
  a_rom_hold: assert property ((mode == lsm_pkg::MODE_ROM && mem_we) |=> // R13
    mem_reg[$past(mem_addr)] == $past(mem_reg[mem_addr]))
    else $error("ROM mode wrote the array");

endmodule

// ---- tb/lsm_neighbour.sv ----
`timescale 1ns/1ns
// Neighbour slice: one table whose output feeds the chain input
module lsm_neighbour (
  input wire logic [15:0] nb_cfg,
  input wire logic [3:0] nb_in,
  output logic nb_out
);
  // Combinational, like a real neighbour table output
  always_comb begin
    nb_out = nb_cfg[nb_in];
  end
endmodule

// ---- tb/tb_logic_slice_modes.sv ----
`timescale 1ns/1ns
module tb_logic_slice_modes;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  lsm_pkg::lsm_mode_t mode = lsm_pkg::MODE_LOGIC;
  lsm_pkg::lsm_op_t op = lsm_pkg::OP_ADD;
  logic [15:0] cfg_a = 16'h0, cfg_b = 16'h0, nb_cfg = 16'h0;
  logic [3:0] in_a = 4'h0, in_b = 4'h0, nb_in = 4'h0, addr = 4'h0, wdata = 4'h0, raddr2 = 4'h0;
  logic [1:0] op_a = 2'h0, op_b = 2'h0, load_val = 2'h0, cnt;
  logic l5_sel = 1'h0, chain_sel = 1'h0, cin = 1'h0, add = 1'h0, fast = 1'h0, mbit = 1'h0;
  logic dir_up = 1'h0, aclr = 1'h0, load = 1'h0, we = 1'h0, pdp = 1'h1, chain_in;
  // Registered slice results
  lsm_pkg::lsm_out_t so;
  int num_errors = 0;
  int n_compared = 0;
  // Free-running 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Neighbour slice drives the chain input
  lsm_neighbour nb (.nb_cfg(nb_cfg), .nb_in(nb_in), .nb_out(chain_in));
  // Word 7 preloaded so the configuration image is visible
  lsm_slice #(.MEM_INIT(64'h0000_0000_9000_0000)) dut (.ref_clk(ref_clk), .rstn(rstn), .mode(mode),
    .lut_cfg_a(cfg_a), .lut_cfg_b(cfg_b),
    .lut_in_a(in_a), .lut_in_b(in_b), .lut5_sel(l5_sel), .chain_in(chain_in), .chain_sel(chain_sel),
    .op(op), .op_a(op_a), .op_b(op_b), .carry_in(cin), .addsub_add(add), .fast_carry_config(fast),
    .mult_bit(mbit), .cnt_dir_up(dir_up), .cnt_aclr(aclr), .cnt_load(load), .cnt_load_val(load_val),
    .mem_we(we), .mem_addr(addr), .mem_wdata(wdata), .pseudo_dual_port_ram_cfg(pdp),
    .mem_raddr2(raddr2), .slice_out(so), .cnt(cnt));
  // Single comparison point; four-state compare so unknowns fail
  task chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs change at falling edge; one rising edge later the result is checked
  task tick;
    @(negedge ref_clk);
  endtask
  // Every table input combination, fifth input and chain
  task t_logic;
    for (int i = 0; i < 16; i++) begin
      mode = lsm_pkg::MODE_LOGIC;
      cfg_a = 16'h8000;
      cfg_b = 16'h6996;
      nb_cfg = 16'h0001;
      chain_sel = 1'h1;
      in_a = i[3:0];
      in_b = i[3:0];
      nb_in = i[3:0];
      l5_sel = i[0];
      tick;
      chk("lut0", so.lut0, i == 15);
      chk("lut1", so.lut1, ^i[3:0]);
      chk("lut5", so.lut5, i[0] ? cfg_b[i] : cfg_a[i]);
      chk("wide", so.wide, i == 0);
      chk("sum in logic", so.sum, 2'h0);
    end
  endtask
  // One arithmetic operation, expectation built from operands
  task do_op(input lsm_pkg::lsm_op_t o, input logic [1:0] a, input logic [1:0] b, input logic c,
             input logic ad, input logic mb);
    logic sub;
    logic [1:0] pa, eb;
    logic [2:0] e;
    sub = (o == lsm_pkg::OP_SUB) || (o == lsm_pkg::OP_ADDSUB && !ad);
    pa = (o == lsm_pkg::OP_MULT) ? (a & {2{mb}}) : a;
    eb = sub ? ~b : b;
    e = {1'h0, pa} + {1'h0, eb} + {2'h0, c};
    mode = lsm_pkg::MODE_RIPPLE;
    op = o;
    op_a = a;
    op_b = b;
    cin = c;
    add = ad;
    mbit = mb;
    fast = 1'h1;
    tick;
    chk("sum", so.sum, e[1:0]);
    chk("cout", so.cout, e[2]);
    chk("ge", so.ge, a >= b);
    chk("ne", so.ne, a != b);
    chk("le", so.le, a <= b);
    chk("cgen", so.cgen, ({1'h0, pa} + {1'h0, eb}) > 3);
    chk("cprop", so.cprop, &(pa ^ eb));
    chk("lut0 in ripple", so.lut0, 1'h0);
  endtask
  // All operand pairs for every arithmetic function
  task t_arith;
    for (int a = 0; a < 4; a++) begin
      for (int b = 0; b < 4; b++) begin
        do_op(lsm_pkg::OP_ADD, a[1:0], b[1:0], a[0], 1'h0, 1'h0);
        do_op(lsm_pkg::OP_SUB, a[1:0], b[1:0], b[0], 1'h0, 1'h0);
        do_op(lsm_pkg::OP_ADDSUB, a[1:0], b[1:0], 1'h1, b[1], 1'h0);
        do_op(lsm_pkg::OP_MULT, a[1:0], b[1:0], 1'h0, 1'h0, a[1] ^ b[0]);
      end
    end
    fast = 1'h0;
    tick;
    chk("cgen off", so.cgen, 1'h0);
  endtask
  // Preload, wrap both ways, direction, async clear, refusal outside ripple
  task t_count;
    mode = lsm_pkg::MODE_RIPPLE;
    op = lsm_pkg::OP_UP;
    load = 1'h1;
    load_val = 2'h2;
    tick;
    chk("cnt load", cnt, 2'h2);
    chk("cnt sum", so.sum, 2'h2);
    load = 1'h0;
    tick;
    chk("cnt up", cnt, 2'h3);
    tick;
    chk("cnt wrap", cnt, 2'h0);
    chk("cnt term", so.cout, 1'h1);
    op = lsm_pkg::OP_DOWN;
    tick;
    chk("cnt down", cnt, 2'h3);
    op = lsm_pkg::OP_UPDN;
    dir_up = 1'h0;
    tick;
    chk("cnt updn", cnt, 2'h2);
    mode = lsm_pkg::MODE_LOGIC;
    dir_up = 1'h1;
    tick;
    chk("cnt idle", cnt, 2'h2);
    mode = lsm_pkg::MODE_RIPPLE;
    aclr = 1'h1;
    load = 1'h1;
    #1;
    chk("cnt aclr", cnt, 2'h0);
    tick;
    chk("cnt aclr load", cnt, 2'h0);
    aclr = 1'h0;
    load = 1'h0;
  endtask
  // Preload, same-cycle old data, full depth, second port, read-only mode
  task t_mem;
    mode = lsm_pkg::MODE_RAM;
    addr = 4'h7;
    tick;
    chk("rdata init", so.rdata, 4'h9);
    for (int i = 0; i < 16; i++) begin
      we = 1'h1;
      addr = i[3:0];
      wdata = ~i[3:0];
      tick;
      chk("rdata old", so.rdata, (i == 7) ? 4'h9 : 4'h0);
    end
    we = 1'h0;
    for (int i = 0; i < 16; i++) begin
      addr = i[3:0];
      raddr2 = 4'hf - i[3:0];
      tick;
      chk("rdata", so.rdata, ~i[3:0]);
      chk("rdata2", so.rdata2, i[1:0]);
    end
    // Write then read the same word in the next cycle
    we = 1'h1;
    addr = 4'h3;
    wdata = 4'h5;
    tick;
    we = 1'h0;
    tick;
    chk("rdata back", so.rdata, 4'h5);
    mode = lsm_pkg::MODE_ROM;
    we = 1'h1;
    addr = 4'h5;
    wdata = 4'h0;
    pdp = 1'h0;
    tick;
    we = 1'h0;
    tick;
    chk("rom keep", so.rdata, 4'ha);
    chk("rdata2 off", so.rdata2, 2'h0);
  endtask
  // Mid-run reset restores the configured memory image
  task t_reload;
    rstn = 1'h0;
    tick;
    rstn = 1'h1;
    mode = lsm_pkg::MODE_RAM;
    addr = 4'h7;
    tick;
    chk("reload word", so.rdata, 4'h9);
  endtask
  // Verdict and end of run
  task report_and_stop;
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence after 20 cycles of reset
  initial begin
    repeat (20) @(posedge ref_clk);
    tick;
    rstn = 1'h1;
    t_logic;
    t_arith;
    t_count;
    t_mem;
    t_reload;
    report_and_stop;
  end
  // Hang guard: far beyond the whole run
  initial begin
    #500000;
    num_errors++;
    report_and_stop;
  end
endmodule
